//--- mtcs_timer_ctrl.sv
// control, status and interrupt logic of the multiplying edge-interval timer
// assumes counter conditions and clock-bus lines come from logic on ref_clk
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module mtcs_timer_ctrl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [mtcs_pkg::mtcs_aw-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [mtcs_pkg::mtcs_clock_lines-1:0] clock_bus,
  input wire logic timer_b_run,
  input wire mtcs_pkg::mtcs_counter_s cnt_in,
  output mtcs_pkg::mtcs_control_s ctl_out,
  output logic irq
);
  import mtcs_pkg::*;

  logic [1:0] count_clock_select_r;
  logic [7:0] io_control_r;
  logic [mtcs_flag_count-1:0] flags_r;
  logic [mtcs_flag_count-1:0] flags_nxt;
  logic [mtcs_flag_count-1:0] armed_r;
  logic [mtcs_flag_count-1:0] flag_set;
  logic [mtcs_flag_count-1:0] flag_clr;
  logic [5:0] irq_enable_r;
  logic [mtcs_clock_lines-1:0] clock_bus_r;
  logic wait_r;
  logic [31:0] readdata_r;
  mtcs_control_s ctl_r;
  logic irq_r;
  logic irq_nxt;
  mtcs_irq_state_e irq_state_r;
  mtcs_irq_state_e irq_state_nxt;
  logic wr_go;
  logic rd_go;
  logic sel_rise;
  logic accepted_event;
  logic [1:0] irq_timing;

  function automatic logic hit(input logic [mtcs_aw-1:0] a, input logic [mtcs_aw-1:0] off, input logic [3:0] be);
    hit = (a == off) && be[0];
  endfunction : hit

  assign avs_waitrequest = wait_r;
  assign avs_readdata = readdata_r;
  assign ctl_out = ctl_r;
  assign irq = irq_r;
  assign irq_timing = irq_enable_r[mtcs_irq_timing_lsb +: 2];
  assign accepted_event = cnt_in.ext_event && io_control_r[mtcs_event_input_enable_bit];

  // bus handshake: one wait cycle; writes land on accept, read data captured before it
  assign wr_go = avs_write && !wait_r;
  assign rd_go = avs_read && wait_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((avs_read || avs_write) && wait_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      readdata_r <= 32'h0;
    end else if (rd_go) begin
      readdata_r <= 32'h0;
      if (hit(avs_address, mtcs_off_clock_control, avs_byteenable)) begin
        readdata_r[1:0] <= count_clock_select_r;
      end
      if (hit(avs_address, mtcs_off_io_control, avs_byteenable)) begin
        readdata_r[7:0] <= io_control_r;
      end
      if (hit(avs_address, mtcs_off_flag_status, avs_byteenable)) begin
        readdata_r[mtcs_flag_count-1:0] <= flags_r;
      end
      if (hit(avs_address, mtcs_off_irq_enable, avs_byteenable)) begin
        readdata_r[5:0] <= irq_enable_r;
      end
    end
  end

  // control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_clock_select_r <= mtcs_reset_byte[1:0];
      io_control_r <= mtcs_reset_byte;
      irq_enable_r <= mtcs_reset_byte[5:0];
    end else if (wr_go) begin
      if (hit(avs_address, mtcs_off_clock_control, avs_byteenable)) begin
        count_clock_select_r <= avs_writedata[mtcs_cksel_lsb +: 2];
      end
      if (hit(avs_address, mtcs_off_io_control, avs_byteenable)) begin
        io_control_r <= avs_writedata[7:0] & mtcs_io_write_mask;
      end
      if (hit(avs_address, mtcs_off_irq_enable, avs_byteenable)) begin
        irq_enable_r <= avs_writedata[5:0] & mtcs_irq_enable_write_mask[5:0];
      end
    end
  end

  // flag set and clear conditions
  always_comb begin
    flag_set = '0;
    flag_set[mtcs_mult_match_flag_bit] = cnt_in.mult_match && io_control_r[mtcs_mult_match_enable_bit];
    flag_set[mtcs_event_match_flag_bit] = cnt_in.event_match;
    flag_set[mtcs_interval_capture_flag_bit] = accepted_event;
    flag_set[mtcs_interval_match_flag_bit] = cnt_in.interval_match;
    flag_clr = '0;
    if (wr_go && hit(avs_address, mtcs_off_flag_status, avs_byteenable)) begin
      flag_clr = armed_r & ~avs_writedata[mtcs_flag_count-1:0];
    end
    if (irq_timing == mtcs_timing_second_event && cnt_in.secondary_match) begin
      flag_clr[mtcs_mult_match_flag_bit] = 1'b1;
    end
    flags_nxt = flag_set | (flags_r & ~flag_clr);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_r <= mtcs_reset_byte[mtcs_flag_count-1:0];
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // a flag may be cleared by a write only once it has been read as 1
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      armed_r <= '0;
    end else begin
      armed_r <= (armed_r | ((rd_go && hit(avs_address, mtcs_off_flag_status, avs_byteenable)) ?
                 flags_r : '0)) & flags_nxt;
    end
  end

  // counter controls
  assign sel_rise = clock_bus[count_clock_select_r] && !clock_bus_r[count_clock_select_r];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clock_bus_r <= '0;
      ctl_r <= '0;
    end else begin
      clock_bus_r <= clock_bus;
      ctl_r.interval_count_en <= sel_rise && timer_b_run;
      ctl_r.reload_count_en <= sel_rise && timer_b_run;
      ctl_r.load_source_select <= io_control_r[mtcs_load_source_select_bit];
      ctl_r.corrected_clock_halt <= io_control_r[mtcs_corrected_clock_halt_bit];
      ctl_r.accepted_event <= accepted_event;
      ctl_r.reload_update <= accepted_event && !io_control_r[mtcs_reload_update_inhibit_bit];
      ctl_r.second_correction_stop <= io_control_r[mtcs_correction_stop_select_bit] &&
                                      cnt_in.correction_equal;
    end
  end

  // timing of the multiplied match interrupt
  always_comb begin
    irq_state_nxt = irq_state_r;
    if (!flags_r[mtcs_mult_match_flag_bit] || !irq_enable_r[mtcs_mult_match_flag_bit]) begin
      irq_state_nxt = mtcs_irq_idle;
    end else begin
      unique case (irq_state_r)
        mtcs_irq_idle: begin
          if (irq_timing == mtcs_timing_on_flag) begin
            irq_state_nxt = mtcs_irq_ready;
          end else if (irq_timing == mtcs_timing_first_event) begin
            irq_state_nxt = mtcs_irq_wait_one;
          end else begin
            irq_state_nxt = mtcs_irq_wait_two;
          end
        end
        mtcs_irq_wait_two: begin
          if (cnt_in.secondary_match) begin
            irq_state_nxt = mtcs_irq_blocked;
          end else if (accepted_event) begin
            irq_state_nxt = mtcs_irq_wait_one;
          end
        end
        mtcs_irq_wait_one: begin
          if (irq_timing == mtcs_timing_second_event && cnt_in.secondary_match) begin
            irq_state_nxt = mtcs_irq_blocked;
          end else if (accepted_event) begin
            irq_state_nxt = mtcs_irq_ready;
          end
        end
        mtcs_irq_ready: irq_state_nxt = mtcs_irq_ready;
        mtcs_irq_blocked: irq_state_nxt = mtcs_irq_blocked;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_state_r <= mtcs_irq_idle;
    end else begin
      irq_state_r <= irq_state_nxt;
    end
  end

  always_comb begin
    irq_nxt = |(flags_r[mtcs_event_match_flag_bit:0] & irq_enable_r[mtcs_event_match_flag_bit:0]);
    irq_nxt = irq_nxt || (irq_state_r == mtcs_irq_ready);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // checks
  property p_mult_set;
    @(posedge ref_clk) disable iff (reset)
      cnt_in.mult_match && io_control_r[mtcs_mult_match_enable_bit] |=> flags_r[mtcs_mult_match_flag_bit];
  endproperty
  a_mult_set: assert property (p_mult_set) else $error("mult match flag not set");

  property p_match_gate;
    @(posedge ref_clk) disable iff (reset)
      !flags_r[mtcs_mult_match_flag_bit] && !io_control_r[mtcs_mult_match_enable_bit] |=>
      !flags_r[mtcs_mult_match_flag_bit];
  endproperty
  a_match_gate: assert property (p_match_gate) else $error("mult flag set while compare disabled");

  property p_interval_set;
    @(posedge ref_clk) disable iff (reset)
      cnt_in.interval_match |=> flags_r[mtcs_interval_match_flag_bit];
  endproperty
  a_interval_set: assert property (p_interval_set) else $error("interval match flag not set");

  property p_no_sw_set;
    @(posedge ref_clk) disable iff (reset)
      !flags_r[mtcs_event_match_flag_bit] && !cnt_in.event_match |=> !flags_r[mtcs_event_match_flag_bit];
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("event flag set without match");

  property p_clear_needs_read;
    @(posedge ref_clk) disable iff (reset)
      flags_r[mtcs_interval_match_flag_bit] && !armed_r[mtcs_interval_match_flag_bit] |=>
      flags_r[mtcs_interval_match_flag_bit];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared before read");

  property p_event_gate;
    @(posedge ref_clk) disable iff (reset)
      !io_control_r[mtcs_event_input_enable_bit] ##1 !io_control_r[mtcs_event_input_enable_bit] |->
      !ctl_r.accepted_event && !ctl_r.reload_update;
  endproperty
  a_event_gate: assert property (p_event_gate) else $error("event passed while disabled");

  property p_count_edge;
    @(posedge ref_clk) disable iff (reset)
      ctl_r.interval_count_en |-> $past(timer_b_run) && $past(sel_rise);
  endproperty
  a_count_edge: assert property (p_count_edge) else $error("count without selected edge");

  property p_irq_now;
    @(posedge ref_clk) disable iff (reset)
      flags_r[mtcs_interval_capture_flag_bit] && irq_enable_r[mtcs_interval_capture_flag_bit] |=> irq_r;
  endproperty
  a_irq_now: assert property (p_irq_now) else $error("capture interrupt missing");

  property p_second_event;
    @(posedge ref_clk) disable iff (reset)
      irq_state_r == mtcs_irq_wait_two |=> irq_state_r != mtcs_irq_ready;
  endproperty
  a_second_event: assert property (p_second_event) else $error("early multiplied match interrupt");

  property p_bus_answer;
    @(posedge ref_clk) disable iff (reset)
      (avs_read || avs_write) && wait_r |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus not answered in one cycle");

  property p_reload_gate;
    @(posedge ref_clk) disable iff (reset)
      ctl_r.reload_update |-> $past(accepted_event) && !$past(io_control_r[mtcs_reload_update_inhibit_bit]);
  endproperty
  a_reload_gate: assert property (p_reload_gate) else $error("reload update while inhibited");

  property p_reload_edge;
    @(posedge ref_clk) disable iff (reset)
      ctl_r.reload_count_en |-> $past(timer_b_run) && $past(sel_rise);
  endproperty
  a_reload_edge: assert property (p_reload_edge) else $error("reload count without selected edge");

  property p_load_source;
    @(posedge ref_clk) disable iff (reset)
      ctl_r.load_source_select == $past(io_control_r[mtcs_load_source_select_bit]);
  endproperty
  a_load_source: assert property (p_load_source) else $error("load source not following control");

  property p_halt_follow;
    @(posedge ref_clk) disable iff (reset)
      ctl_r.corrected_clock_halt == $past(io_control_r[mtcs_corrected_clock_halt_bit]);
  endproperty
  a_halt_follow: assert property (p_halt_follow) else $error("corrected clock halt not following control");

  property p_auto_clear;
    @(posedge ref_clk) disable iff (reset)
      irq_timing == mtcs_timing_second_event && cnt_in.secondary_match && !flag_set[mtcs_mult_match_flag_bit] |=>
      !flags_r[mtcs_mult_match_flag_bit];
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("mult match flag not cleared by secondary match");

  property p_first_event;
    @(posedge ref_clk) disable iff (reset)
      irq_state_r == mtcs_irq_wait_one &&
      !(|(flags_r[mtcs_event_match_flag_bit:0] & irq_enable_r[mtcs_event_match_flag_bit:0])) |=> !irq_r;
  endproperty
  a_first_event: assert property (p_first_event) else $error("multiplied match interrupt before event");

  c_irq_second: cover property (@(posedge ref_clk) disable iff (reset)
    irq_state_r == mtcs_irq_wait_two ##[1:50] irq_state_r == mtcs_irq_ready);
  c_blocked: cover property (@(posedge ref_clk) disable iff (reset) irq_state_r == mtcs_irq_blocked);
  c_sw_clear: cover property (@(posedge ref_clk) disable iff (reset)
    flags_r[mtcs_interval_match_flag_bit] ##1 !flags_r[mtcs_interval_match_flag_bit]);
  c_set_wins: cover property (@(posedge ref_clk) disable iff (reset) |(flag_set & flag_clr));
  c_first_event: cover property (@(posedge ref_clk) disable iff (reset)
    irq_state_r == mtcs_irq_wait_one ##1 irq_state_r == mtcs_irq_ready);
endmodule : mtcs_timer_ctrl

//--- mtcs_pkg.sv
// package for the multiplier timer control and status block
// assumes a 32-bit avalon-mm bus with one word per register
package mtcs_pkg;
  localparam int mtcs_aw = 4;
  localparam logic [mtcs_aw-1:0] mtcs_off_clock_control = 4'h0;
  localparam logic [mtcs_aw-1:0] mtcs_off_io_control = 4'h4;
  localparam logic [mtcs_aw-1:0] mtcs_off_flag_status = 4'h8;
  localparam logic [mtcs_aw-1:0] mtcs_off_irq_enable = 4'hc;
  localparam logic [7:0] mtcs_reset_byte = 8'h00;
  // clock control fields
  localparam int mtcs_cksel_lsb = 0;
  // io control fields
  localparam int mtcs_load_source_select_bit = 7;
  localparam int mtcs_corrected_clock_halt_bit = 6;
  localparam int mtcs_event_input_enable_bit = 5;
  localparam int mtcs_reload_update_inhibit_bit = 4;
  localparam int mtcs_correction_stop_select_bit = 3;
  localparam int mtcs_mult_match_enable_bit = 0;
  localparam logic [7:0] mtcs_io_write_mask = 8'hf9;
  // flag status fields
  localparam int mtcs_mult_match_flag_bit = 3;
  localparam int mtcs_event_match_flag_bit = 2;
  localparam int mtcs_interval_capture_flag_bit = 1;
  localparam int mtcs_interval_match_flag_bit = 0;
  localparam int mtcs_flag_count = 4;
  // irq enable fields
  localparam int mtcs_irq_timing_lsb = 4;
  localparam logic [7:0] mtcs_irq_enable_write_mask = 8'h3f;
  localparam logic [1:0] mtcs_timing_on_flag = 2'h0;
  localparam logic [1:0] mtcs_timing_first_event = 2'h1;
  localparam logic [1:0] mtcs_timing_second_event = 2'h2;
  localparam int mtcs_clock_lines = 4;

  typedef enum {
    mtcs_irq_idle,
    mtcs_irq_wait_two,
    mtcs_irq_wait_one,
    mtcs_irq_ready,
    mtcs_irq_blocked
  } mtcs_irq_state_e;

  // conditions from the counters, same clock domain
  typedef struct packed {
    logic interval_match;
    logic event_match;
    logic mult_match;
    logic secondary_match;
    logic correction_equal;
    logic ext_event;
  } mtcs_counter_s;

  // controls to the counters
  typedef struct packed {
    logic interval_count_en;
    logic reload_count_en;
    logic load_source_select;
    logic corrected_clock_halt;
    logic accepted_event;
    logic reload_update;
    logic second_correction_stop;
  } mtcs_control_s;
endpackage : mtcs_pkg

//--- mtcs_counter_model.sv
// model of the counters and upstream event timer facing the control block
// assumes bench requests arrive as one-cycle pulses or held levels on ref_clk
`timescale 1ns/1ps
module mtcs_counter_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clr,
  input wire mtcs_pkg::mtcs_counter_s req,
  input wire mtcs_pkg::mtcs_control_s ctl_in,
  output mtcs_pkg::mtcs_counter_s cnt_out,
  output logic [7:0] steps,
  output logic [7:0] accepted,
  output logic [7:0] reloads
);
  import mtcs_pkg::*;
  // conditions reach the block one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_out <= '0;
    end else begin
      cnt_out <= req;
    end
  end
  // consumer side: counts the interval_count_en, accepted_event and reload_update pulses that the block hands out
  always_ff @(posedge ref_clk) begin
    if (reset || clr) begin
      steps <= 8'h00;
      accepted <= 8'h00;
      reloads <= 8'h00;
    end else begin
      steps <= steps + {7'h00, ctl_in.interval_count_en};
      accepted <= accepted + {7'h00, ctl_in.accepted_event};
      reloads <= reloads + {7'h00, ctl_in.reload_update};
    end
  end
endmodule : mtcs_counter_model

//--- tb_multiplier_timer_control_status.sv
// testbench of the timer control and status block
// assumes the counter model stands on the far side of cnt_in and ctl_out
`timescale 1ns/1ps
module tb_multiplier_timer_control_status;
  import mtcs_pkg::*;
  logic ref_clk;
  logic reset;
  logic [mtcs_aw-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] clock_bus;
  logic timer_b_run;
  logic clr;
  logic irq;
  mtcs_counter_s cnt_in;
  mtcs_counter_s req;
  mtcs_control_s ctl_out;
  logic [7:0] steps;
  logic [7:0] accepted;
  logic [7:0] reloads;
  logic [31:0] r;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  mtcs_timer_ctrl uut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .clock_bus(clock_bus),
    .timer_b_run(timer_b_run), .cnt_in(cnt_in), .ctl_out(ctl_out), .irq(irq));
  mtcs_counter_model partner (.ref_clk(ref_clk), .reset(reset), .clr(clr), .req(req), .ctl_in(ctl_out),
    .cnt_out(cnt_in), .steps(steps), .accepted(accepted), .reloads(reloads));
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      bad_count = bad_count + 1;
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [mtcs_aw-1:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    r = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic wr(input logic [mtcs_aw-1:0] a, input logic [31:0] d);
    bus(a, 1'h1, d, 4'h1);
  endtask : wr
  task automatic rd(input logic [mtcs_aw-1:0] a);
    bus(a, 1'h0, 32'h0, 4'h1);
  endtask : rd
  task automatic pulse(input mtcs_counter_s v);
    @(posedge ref_clk);
    req <= v;
    @(posedge ref_clk);
    req <= '0;
    repeat (4) @(posedge ref_clk);
  endtask : pulse
  task automatic count_clear();
    @(posedge ref_clk);
    clr <= 1'h1;
    @(posedge ref_clk);
    clr <= 1'h0;
  endtask : count_clear
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4));
      chk("reset value", r, 32'h0);
    end
  endtask : t_reset
  task automatic t_access();
    bus(mtcs_off_clock_control, 1'h1, 32'hffffffff, 4'hf);
    rd(mtcs_off_clock_control);
    chk("clock control word", r, 32'h3);
    bus(mtcs_off_io_control, 1'h1, 32'hffffffff, 4'hf);
    bus(mtcs_off_io_control, 1'h0, 32'h0, 4'hf);
    chk("io control word", r, 32'hf9);
    wr(mtcs_off_flag_status, 32'hff);
    bus(mtcs_off_flag_status, 1'h0, 32'h0, 4'hf);
    chk("flags written 1", r, 32'h0);
    bus(mtcs_off_clock_control, 1'h1, 32'h0, 4'h0);
    rd(mtcs_off_clock_control);
    chk("write without lane 0", r, 32'h3);
    rd(4'h2);
    chk("unmapped read", r, 32'h0);
    wr(mtcs_off_io_control, 32'h0);
  endtask : t_access
  task automatic t_clock();
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      timer_b_run <= 1'h0;
      clock_bus <= 4'h0;
      wr(mtcs_off_clock_control, 32'(s));
      @(posedge ref_clk);
      timer_b_run <= 1'h1;
      count_clear();
      clock_bus <= ~(4'h1 << s);
      repeat (4) @(posedge ref_clk);
      chk("unselected line steps", {24'h0, steps}, 32'h0);
      clock_bus <= 4'hf;
      repeat (2) @(posedge ref_clk);
      chk("reload count enable", {31'h0, ctl_out.reload_count_en}, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk("selected line steps", {24'h0, steps}, 32'h1);
    end
    timer_b_run <= 1'h0;
    count_clear();
    clock_bus <= 4'h0;
    repeat (3) @(posedge ref_clk);
    clock_bus <= 4'hf;
    repeat (4) @(posedge ref_clk);
    chk("steps while stopped", {24'h0, steps}, 32'h0);
  endtask : t_clock
  task automatic t_io();
    wr(mtcs_off_io_control, 32'hc8);
    @(posedge ref_clk);
    req <= mtcs_counter_s'(6'h02);
    repeat (4) @(posedge ref_clk);
    chk("load source", {31'h0, ctl_out.load_source_select}, 32'h1);
    chk("corrected halt", {31'h0, ctl_out.corrected_clock_halt}, 32'h1);
    chk("second stop", {31'h0, ctl_out.second_correction_stop}, 32'h1);
    wr(mtcs_off_io_control, 32'h40);
    repeat (3) @(posedge ref_clk);
    chk("load source off", {31'h0, ctl_out.load_source_select}, 32'h0);
    chk("second stop off", {31'h0, ctl_out.second_correction_stop}, 32'h0);
    req <= '0;
    wr(mtcs_off_io_control, 32'h20);
    repeat (2) @(posedge ref_clk);
    chk("halt released", {31'h0, ctl_out.corrected_clock_halt}, 32'h0);
    count_clear();
    pulse(mtcs_counter_s'(6'h01));
    chk("events accepted", {24'h0, accepted, reloads}, 32'h0101);
    wr(mtcs_off_io_control, 32'h30);
    pulse(mtcs_counter_s'(6'h01));
    chk("reload inhibited", {24'h0, accepted, reloads}, 32'h0201);
    wr(mtcs_off_io_control, 32'h00);
    pulse(mtcs_counter_s'(6'h01));
    chk("events ignored", {24'h0, accepted, reloads}, 32'h0201);
  endtask : t_io
  task automatic t_flags();
    pulse(mtcs_counter_s'(6'h08));
    rd(mtcs_off_flag_status);
    chk("match disabled", r, 32'h2);
    wr(mtcs_off_flag_status, 32'h0);
    wr(mtcs_off_io_control, 32'h21);
    pulse(mtcs_counter_s'(6'h39));
    wr(mtcs_off_flag_status, 32'h0);
    rd(mtcs_off_flag_status);
    chk("flags set", r, 32'hf);
    wr(mtcs_off_flag_status, 32'he);
    rd(mtcs_off_flag_status);
    chk("one flag cleared", r, 32'he);
    wr(mtcs_off_flag_status, 32'h0);
    rd(mtcs_off_flag_status);
    chk("all cleared", r, 32'h0);
  endtask : t_flags
  task automatic t_irq();
    wr(mtcs_off_irq_enable, 32'h01);
    pulse(mtcs_counter_s'(6'h20));
    chk("irq enabled flag", {31'h0, irq}, 32'h1);
    rd(mtcs_off_flag_status);
    wr(mtcs_off_flag_status, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq after clear", {31'h0, irq}, 32'h0);
    wr(mtcs_off_irq_enable, 32'h18);
    pulse(mtcs_counter_s'(6'h08));
    chk("irq waits for event", {31'h0, irq}, 32'h0);
    pulse(mtcs_counter_s'(6'h01));
    chk("irq at first event", {31'h0, irq}, 32'h1);
    rd(mtcs_off_flag_status);
    wr(mtcs_off_flag_status, 32'h0);
    wr(mtcs_off_irq_enable, 32'h28);
    pulse(mtcs_counter_s'(6'h08));
    pulse(mtcs_counter_s'(6'h04));
    rd(mtcs_off_flag_status);
    chk("secondary auto clear", r, 32'h0);
    chk("irq blocked", {31'h0, irq}, 32'h0);
    pulse(mtcs_counter_s'(6'h08));
    pulse(mtcs_counter_s'(6'h01));
    chk("irq waits for second event", {31'h0, irq}, 32'h0);
    pulse(mtcs_counter_s'(6'h01));
    chk("irq at second event", {31'h0, irq}, 32'h1);
  endtask : t_irq
  initial begin
    reset = 1'h1;
    avs_address = '0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    clock_bus = 4'h0;
    timer_b_run = 1'h0;
    req = '0;
    clr = 1'h0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    t_reset();
    t_access();
    t_clock();
    t_io();
    t_flags();
    t_irq();
    stop_test();
  end
endmodule : tb_multiplier_timer_control_status
